//--- inc/charger_regs_pkg.sv
package charger_regs_pkg;
  // link address and register indexes
  localparam logic [6:0] DEV_ADDR = 7'h36;
  localparam logic [7:0] STATE_REPORT_IDX = 8'h00;
  localparam logic [7:0] MAIN_CONTROL_IDX = 8'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // state field codes
  localparam logic [3:0] LAST_CHARGE_CODE = 4'hB;
  localparam logic [3:0] FAULT_CODE = 4'hB;
  localparam logic [3:0] BOOST_WAIT_CODE = 4'hC;
  localparam logic [3:0] BOOST_RUN_CODE = 4'hD;
  localparam logic [3:0] BOOST_OVERLOAD_CODE = 4'hE;

  // boost phase reported by the boost controller
  typedef enum logic [1:0] {
    BOOST_WAIT = 2'h0,
    BOOST_RUN = 2'h1,
    BOOST_OVERLOAD = 2'h2
  } boost_phase_type;

  // status byte layout, bit 7 first
  typedef struct packed {
    logic [3:0] state;
    logic batfet_present;
    logic thermistor_present;
    logic status_event_summary;
    logic fault_event_summary;
  } state_report_type;

  // control byte layout, bit 7 first
  typedef struct packed {
    logic reg_reset;
    logic charge_enable;
    logic boost_supply_enable;
    logic thermistor_enable;
    logic junction_temp_derate_enable;
    logic warm_battery_reduce_select;
    logic timer_restart;
    logic global_int_mask;
  } main_control_type;

  localparam main_control_type MAIN_CONTROL_RESET = 8'h51;

  // pending flags of the event registers held elsewhere
  typedef struct packed {
    logic [7:0] status_events;
    logic [7:0] charger_event_register_one;
    logic [7:0] charger_event_register_two;
    logic [7:0] boost_event_register;
  } event_regs_type;
endpackage : charger_regs_pkg

//--- hdl/i2c_line_events.sv
`timescale 1ns/1ps
module i2c_line_events (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  // detected events, one cycle each
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o
);
  logic scl_prev_r;
  logic sda_prev_r;

  // previous line levels, idle bus is high
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= scl_i;
      sda_prev_r <= sda_i;
    end
  end

  // sda moving while scl high marks start or stop
  assign scl_rise_o = !scl_prev_r && scl_i;
  assign scl_fall_o = scl_prev_r && !scl_i;
  assign start_o = scl_prev_r && scl_i && sda_prev_r && !sda_i;
  assign stop_o = scl_prev_r && scl_i && !sda_prev_r && sda_i;
endmodule : i2c_line_events

//--- hdl/state_report_builder.sv
`timescale 1ns/1ps
module state_report_builder (
  // charge and boost state
  input wire logic [3:0] charge_state_i,
  input wire logic boost_active_i,
  input charger_regs_pkg::boost_phase_type boost_phase_i,
  // presence detection
  input wire logic batfet_present_i,
  input wire logic thermistor_present_i,
  // pending event flags
  input charger_regs_pkg::event_regs_type event_regs_i,
  // assembled status byte
  output charger_regs_pkg::state_report_type report_o
);
  import charger_regs_pkg::*;

  // whole status byte from one process; boost codes win in boost mode
  always_comb begin
    report_o.state = FAULT_CODE;
    if (boost_active_i) begin
      unique case (boost_phase_i)
        BOOST_WAIT: report_o.state = BOOST_WAIT_CODE;
        BOOST_RUN: report_o.state = BOOST_RUN_CODE;
        BOOST_OVERLOAD: report_o.state = BOOST_OVERLOAD_CODE;
        default: report_o.state = BOOST_OVERLOAD_CODE;
      endcase
    end else if (charge_state_i <= LAST_CHARGE_CODE) begin
      report_o.state = charge_state_i;
    end
    // live presence bits and event summaries
    report_o.batfet_present = batfet_present_i;
    report_o.thermistor_present = thermistor_present_i;
    report_o.status_event_summary =
      |event_regs_i.status_events;
    report_o.fault_event_summary =
      |{event_regs_i.charger_event_register_one,
        event_regs_i.charger_event_register_two,
        event_regs_i.boost_event_register};
  end
endmodule : state_report_builder

//--- hdl/charger_status_control_regs.sv
`timescale 1ns/1ps
// Functional notes
// - answer only 7-bit address 0110110; lowest bit picks read or write
// - status bits 7-4 carry the charge state code 0000 to 1011
// - in boost mode the state field shows 1100, 1101 or 1110
// - status bit 3 shows battery fet presence, read-only, not register-reset
// - status bit 2 shows thermistor presence, read-only
// - status bit 1 is high while any status-event flag is pending
// - status bit 0 is high while any charger or boost event is pending
// - writing 1 to control bit 7 resets all registers; bit reads 0
// - control bit 6 low halts charging, high enables it; resets high
// - control bit 5 or the otg pin requests boost; bit resets low
// - bit 4 high lets battery temperature shape charging; resets high
// - control bit 3 high derates current when junction is hot; resets low
// - warm battery holds charge when bit 2 is 0, reduces when 1
// - writing 1 to control bit 1 restarts the charge timer, self-clearing
// - control bit 0 high masks all interrupts; resets high
// - writes take index then data bytes at incrementing indexes
// - reads start at the last written index and auto-increment
module charger_status_control_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // charger core state
  input wire logic [3:0] charge_state_i,
  input wire logic boost_active_i,
  input charger_regs_pkg::boost_phase_type boost_phase_i,
  input wire logic batfet_present_i,
  input wire logic thermistor_present_i,
  input charger_regs_pkg::event_regs_type event_regs_i,
  // sensed conditions and pins
  input wire logic otg_pin_i,
  input wire logic battery_warm_i,
  input wire logic junction_hot_i,
  input wire logic event_pulse_i,
  // controls to the charger core
  output logic charge_enable_o,
  output logic boost_request_o,
  output logic temp_profile_enable_o,
  output logic current_derate_o,
  output logic charge_hold_o,
  output logic charge_reduce_o,
  output logic charge_timer_restart_o,
  output logic register_reset_o,
  output logic interrupt_mask_o,
  output logic flag_event_o
);
  import charger_regs_pkg::*;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_ADDR_ACK = 9'h004,
    S_INDEX = 9'h008,
    S_INDEX_ACK = 9'h010,
    S_WDATA = 9'h020,
    S_WDATA_ACK = 9'h040,
    S_RDATA = 9'h080,
    S_RDATA_ACK = 9'h100
  } link_state_type;

  logic [1:0] reset_sync_r;
  logic sys_resetn;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  link_state_type state_r;
  link_state_type state_nxt;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] index_r;
  logic read_op_r;
  logic master_nack_r;
  logic sda_oe_r;
  logic sda_level_r;
  logic byte_done;
  logic addr_hit;
  logic write_fire;
  logic ctrl_write;
  logic read_fire;
  logic [7:0] rd_byte;
  state_report_type state_report;
  main_control_type ctrl_r;
  logic boost_request_r;
  logic derate_r;
  logic hold_r;
  logic reduce_r;
  logic reg_reset_pulse_r;
  logic flag_event_r;

  // read decode; action bits always read as zero
  function automatic logic [7:0] read_reg(input logic [7:0] idx,
                                          input state_report_type rep,
                                          input main_control_type ctl);
    main_control_type vis;
    vis = ctl;
    vis.reg_reset = 1'b0;
    vis.timer_restart = 1'b0;
    if (idx == STATE_REPORT_IDX) begin
      return rep;
    end else if (idx == MAIN_CONTROL_IDX) begin
      return vis;
    end
    return 8'h00;
  endfunction : read_reg

  // reset release through two flip-flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reset_sync_r <= 2'b00;
    end else begin
      reset_sync_r <= {reset_sync_r[0], 1'b1};
    end
  end
  assign sys_resetn = reset_sync_r[1];

  i2c_line_events u_line_events (
    .clk_i(clk_i),
    .resetn_i(sys_resetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start_seen),
    .stop_o(stop_seen)
  );

  state_report_builder u_report (
    .charge_state_i(charge_state_i),
    .boost_active_i(boost_active_i),
    .boost_phase_i(boost_phase_i),
    .batfet_present_i(batfet_present_i),
    .thermistor_present_i(thermistor_present_i),
    .event_regs_i(event_regs_i),
    .report_o(state_report)
  );

  // byte framing helpers
  assign byte_done = bit_cnt_r == BITS_PER_BYTE;
  assign addr_hit = shift_r[7:1] == DEV_ADDR;
  assign write_fire = scl_fall && state_r == S_WDATA && byte_done;
  assign ctrl_write = write_fire && index_r == MAIN_CONTROL_IDX;
  assign read_fire = scl_fall && state_r == S_RDATA && byte_done;
  assign rd_byte = read_reg(index_r, state_report, ctrl_r);

  // link sequencing, advanced on scl falling edges
  always_comb begin
    state_nxt = state_r;
    if (stop_seen) begin
      state_nxt = S_IDLE;
    end else if (start_seen) begin
      state_nxt = S_ADDR;
    end else if (scl_fall) begin
      unique case (state_r)
        S_IDLE: state_nxt = S_IDLE;
        S_ADDR: begin
          if (byte_done) begin
            state_nxt = addr_hit ? S_ADDR_ACK : S_IDLE;
          end
        end
        S_ADDR_ACK: state_nxt = read_op_r ? S_RDATA : S_INDEX;
        S_INDEX: begin
          if (byte_done) begin
            state_nxt = S_INDEX_ACK;
          end
        end
        S_INDEX_ACK: state_nxt = S_WDATA;
        S_WDATA: begin
          if (byte_done) begin
            state_nxt = S_WDATA_ACK;
          end
        end
        S_WDATA_ACK: state_nxt = S_WDATA;
        S_RDATA: begin
          if (byte_done) begin
            state_nxt = S_RDATA_ACK;
          end
        end
        S_RDATA_ACK: state_nxt = master_nack_r ? S_IDLE : S_RDATA;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge sys_resetn) begin
    if (!sys_resetn) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // bit counting and receive shifting on scl rising edges
  always_ff @(posedge clk_i or negedge sys_resetn) begin
    if (!sys_resetn) begin
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      read_op_r <= 1'b0;
      master_nack_r <= 1'b0;
    end else begin
      if (start_seen || state_nxt != state_r) begin
        bit_cnt_r <= 4'h0;
      end else if (scl_rise && (state_r == S_ADDR ||
                   state_r == S_INDEX || state_r == S_WDATA ||
                   state_r == S_RDATA)) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (scl_rise && (state_r == S_ADDR || state_r == S_INDEX ||
                       state_r == S_WDATA)) begin
        shift_r <= {shift_r[6:0], sda_i};
      end
      if (scl_fall && state_r == S_ADDR && byte_done) begin
        read_op_r <= shift_r[0];
      end
      if (scl_rise && state_r == S_RDATA_ACK) begin
        master_nack_r <= sda_i;
      end
    end
  end

  // data line drive: acknowledge, then read bits msb first
  always_ff @(posedge clk_i or negedge sys_resetn) begin
    if (!sys_resetn) begin
      sda_oe_r <= 1'b0;
      tx_r <= 8'h00;
    end else if (start_seen || stop_seen) begin
      sda_oe_r <= 1'b0;
    end else if (scl_fall) begin
      if (state_nxt == S_ADDR_ACK || state_nxt == S_INDEX_ACK ||
          state_nxt == S_WDATA_ACK) begin
        sda_oe_r <= 1'b1;
      end else if (state_nxt == S_RDATA && state_r != S_RDATA) begin
        sda_oe_r <= !rd_byte[7];
        tx_r <= {rd_byte[6:0], 1'b0};
      end else if (state_nxt == S_RDATA) begin
        sda_oe_r <= !tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end else begin
        sda_oe_r <= 1'b0;
      end
    end
  end

  // open-drain pin only ever pulls low
  always_ff @(posedge clk_i or negedge sys_resetn) begin
    if (!sys_resetn) begin
      sda_level_r <= 1'b0;
    end else begin
      sda_level_r <= 1'b0;
    end
  end

  // register index: set by the write, kept for later reads
  always_ff @(posedge clk_i or negedge sys_resetn) begin
    if (!sys_resetn) begin
      index_r <= 8'h00;
    end else if (scl_fall && state_r == S_INDEX && byte_done) begin
      index_r <= shift_r;
    end else if (write_fire) begin
      index_r <= index_r + 8'h01;
    end else if (read_fire) begin
      index_r <= index_r + 8'h01;
    end
  end

  // control register with reset and self-clearing action bits
  always_ff @(posedge clk_i or negedge sys_resetn) begin
    if (!sys_resetn) begin
      ctrl_r <= MAIN_CONTROL_RESET;
    end else if (ctrl_write && shift_r[7]) begin
      ctrl_r <= MAIN_CONTROL_RESET;
    end else if (ctrl_write) begin
      ctrl_r <= main_control_type'({1'b0, shift_r[6:0]});
    end else begin
      ctrl_r.timer_restart <= 1'b0;
    end
  end

  // pulse asking the other registers to reset
  always_ff @(posedge clk_i or negedge sys_resetn) begin
    if (!sys_resetn) begin
      reg_reset_pulse_r <= 1'b0;
    end else begin
      reg_reset_pulse_r <= ctrl_write && shift_r[7];
    end
  end

  // derived control levels toward the charger core
  always_ff @(posedge clk_i or negedge sys_resetn) begin
    if (!sys_resetn) begin
      boost_request_r <= 1'b0;
      derate_r <= 1'b0;
      hold_r <= 1'b0;
      reduce_r <= 1'b0;
    end else begin
      boost_request_r <= ctrl_r.boost_supply_enable || otg_pin_i;
      derate_r <= junction_hot_i &&
                  ctrl_r.junction_temp_derate_enable;
      hold_r <= battery_warm_i && ctrl_r.thermistor_enable &&
                !ctrl_r.warm_battery_reduce_select;
      reduce_r <= battery_warm_i && ctrl_r.thermistor_enable &&
                  ctrl_r.warm_battery_reduce_select;
    end
  end

  // event pulse gated by the global mask
  always_ff @(posedge clk_i or negedge sys_resetn) begin
    if (!sys_resetn) begin
      flag_event_r <= 1'b0;
    end else begin
      flag_event_r <= event_pulse_i &&
                      !ctrl_r.global_int_mask;
    end
  end

  // outputs, each from a flip-flop
  assign sda_o = sda_level_r;
  assign sda_oe_o = sda_oe_r;
  assign charge_enable_o = ctrl_r.charge_enable;
  assign boost_request_o = boost_request_r;
  assign temp_profile_enable_o = ctrl_r.thermistor_enable;
  assign current_derate_o = derate_r;
  assign charge_hold_o = hold_r;
  assign charge_reduce_o = reduce_r;
  assign charge_timer_restart_o = ctrl_r.timer_restart;
  assign register_reset_o = reg_reset_pulse_r;
  assign interrupt_mask_o = ctrl_r.global_int_mask;
  assign flag_event_o = flag_event_r;

  // checks on the running design
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!sys_resetn);

  chk_addr_miss_idle: assert property (
    (scl_fall && state_r == S_ADDR && byte_done && !addr_hit)
    |=> state_r == S_IDLE ##1 !sda_oe_o)
    else $error("foreign address was not ignored");

  chk_addr_hit_ack: assert property (
    (scl_fall && state_r == S_ADDR && byte_done && addr_hit)
    |=> ##1 sda_oe_o)
    else $error("own address not acknowledged");

  chk_charge_code: assert property (
    (!boost_active_i && charge_state_i <= LAST_CHARGE_CODE)
    |-> state_report.state == charge_state_i)
    else $error("charge state code mismatch");

  chk_boost_code: assert property (
    (boost_active_i && boost_phase_i == BOOST_RUN)
    |-> state_report.state == BOOST_RUN_CODE)
    else $error("boost run code mismatch");

  chk_presence_bits: assert property (
    state_report.batfet_present == batfet_present_i &&
    state_report.thermistor_present == thermistor_present_i)
    else $error("presence bits mismatch");

  chk_status_summary: assert property (
    state_report.status_event_summary ==
    (event_regs_i.status_events != 8'h00))
    else $error("status summary mismatch");

  chk_fault_summary: assert property (
    state_report.fault_event_summary ==
    (event_regs_i[23:0] != 24'h000000))
    else $error("fault summary mismatch");

  chk_reg_reset_all: assert property (
    (ctrl_write && shift_r[7])
    |=> ctrl_r == MAIN_CONTROL_RESET && register_reset_o
    ##1 !register_reset_o)
    else $error("register reset not applied");

  chk_timer_selfclear: assert property (
    (ctrl_write && !shift_r[7] && shift_r[1])
    |=> charge_timer_restart_o ##1 !charge_timer_restart_o)
    else $error("timer restart did not self-clear");

  chk_boost_request: assert property (
    (ctrl_r.boost_supply_enable || otg_pin_i) |=> boost_request_o)
    else $error("boost request missed");

  chk_warm_hold: assert property (
    (battery_warm_i && ctrl_r.thermistor_enable &&
     !ctrl_r.warm_battery_reduce_select)
    |=> charge_hold_o && !charge_reduce_o)
    else $error("warm battery did not hold charge");

  chk_derate_gate: assert property (
    !ctrl_r.junction_temp_derate_enable |=> !current_derate_o)
    else $error("derate active while disabled");

  chk_mask_gates_flag: assert property (
    ctrl_r.global_int_mask |=> !flag_event_o)
    else $error("event pulse leaked through mask");

  chk_write_increment: assert property (
    write_fire |=> index_r == $past(index_r) + 8'h01)
    else $error("write index did not advance");

  chk_read_increment: assert property (
    read_fire |=> index_r == $past(index_r) + 8'h01)
    else $error("read index did not advance");

  cov_ctrl_write: cover property (ctrl_write && !shift_r[7]);
  cov_reg_reset: cover property (ctrl_write && shift_r[7]);
  cov_read_byte: cover property (read_fire ##[1:40] state_r == S_RDATA);
  cov_read_nack: cover property (state_r == S_RDATA_ACK && master_nack_r
                                 ##1 state_r == S_IDLE);
endmodule : charger_status_control_regs

//--- verification/i2c_host_model.sv
`timescale 1ns/1ps
// bus master model; released lines float high through the pull-ups
module i2c_host_model (
  // clock
  input wire logic clk_i,
  // bus lines, one means released
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // set both lines, then hold them for n falling edges
  task automatic drive(input logic c, input logic d, input int n);
    scl_o = c;
    sda_o = d;
    repeat (n) @(negedge clk_i);
  endtask : drive

  // start or repeated start; data falls while the clock is high
  task automatic start;
    drive(scl_o, 1'b1, 3);
    drive(1'b1, 1'b1, 4);
    drive(1'b1, 1'b0, 4);
    drive(1'b0, 1'b0, 2);
  endtask : start

  // stop; data rises while the clock is high
  task automatic stop;
    drive(1'b0, 1'b0, 3);
    drive(1'b1, 1'b0, 4);
    drive(1'b1, 1'b1, 4);
  endtask : stop

  // one bit: setup, high phase, sample at its end, hold after the fall
  task automatic xfer_bit(input logic v, output logic r);
    drive(1'b0, v, 3);
    drive(1'b1, v, 4);
    r = sda_i;
    drive(1'b0, v, 2);
  endtask : xfer_bit

  // address, index or data byte, msb first, then the answer bit
  task automatic wr_byte(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], r);
    end
    xfer_bit(1'b1, nack);
  endtask : wr_byte

  // read byte with the line released, then acknowledge or not
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, b[i]);
    end
    xfer_bit(nack, r);
  endtask : rd_byte
endmodule : i2c_host_model

//--- verification/charger_status_control_regs_tb.sv
`timescale 1ns/1ps
module charger_status_control_regs_tb;
  import charger_regs_pkg::*;
  logic clk_i, resetn_i, scl, host_sda, sda_o, sda_oe_o, sda, ack;
  logic [3:0] charge_state_i;
  logic boost_active_i, batfet_present_i, thermistor_present_i;
  boost_phase_type boost_phase_i;
  event_regs_type event_regs_i;
  logic otg_pin_i, battery_warm_i, junction_hot_i, event_pulse_i;
  logic charge_enable_o, boost_request_o, temp_profile_enable_o;
  logic current_derate_o, charge_hold_o, charge_reduce_o, flag_event_o;
  logic charge_timer_restart_o, register_reset_o, interrupt_mask_o;
  logic [7:0] rd, expv;
  int n_fail, n_checks, cycles, n_restart, n_regrst, n_flag;

  // open-drain data line with pull-up
  assign sda = host_sda & (sda_oe_o ? sda_o : 1'b1);

  charger_status_control_regs u_charger_status_control_regs (
    .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .charge_state_i(charge_state_i),
    .boost_active_i(boost_active_i), .boost_phase_i(boost_phase_i),
    .batfet_present_i(batfet_present_i),
    .thermistor_present_i(thermistor_present_i),
    .event_regs_i(event_regs_i), .otg_pin_i(otg_pin_i),
    .battery_warm_i(battery_warm_i), .junction_hot_i(junction_hot_i),
    .event_pulse_i(event_pulse_i), .charge_enable_o(charge_enable_o),
    .boost_request_o(boost_request_o),
    .temp_profile_enable_o(temp_profile_enable_o),
    .current_derate_o(current_derate_o), .charge_hold_o(charge_hold_o),
    .charge_reduce_o(charge_reduce_o),
    .charge_timer_restart_o(charge_timer_restart_o),
    .register_reset_o(register_reset_o),
    .interrupt_mask_o(interrupt_mask_o), .flag_event_o(flag_event_o));

  i2c_host_model u_i2c_host_model (
    .clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(host_sda));

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // pulse counters and hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (charge_timer_restart_o === 1'b1) n_restart++;
    if (register_reset_o === 1'b1) n_regrst++;
    if (flag_event_o === 1'b1) n_flag++;
    if (cycles == 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp_v);
    n_checks++;
    if (seen !== exp_v) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp_v);
    end
  endtask : check

  // write address and register index, leave the transfer open
  task automatic set_index(input logic [7:0] idx);
    u_i2c_host_model.start();
    u_i2c_host_model.wr_byte(8'h6C, ack);
    check(8'(ack), 8'h00);
    u_i2c_host_model.wr_byte(idx, ack);
    check(8'(ack), 8'h00);
  endtask : set_index

  task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
    set_index(idx);
    u_i2c_host_model.wr_byte(d, ack);
    check(8'(ack), 8'h00);
    u_i2c_host_model.stop();
    repeat (2) @(negedge clk_i);
  endtask : reg_write

  // read n bytes from idx through a repeated start, comparing each
  task automatic reg_read(input logic [7:0] idx, input logic [7:0] e0,
                          input logic [7:0] e1, input int n);
    set_index(idx);
    u_i2c_host_model.start();
    u_i2c_host_model.wr_byte(8'h6D, ack);
    check(8'(ack), 8'h00);
    for (int i = 0; i < n; i++) begin
      u_i2c_host_model.rd_byte(i == n - 1, rd);
      check(rd, i == 0 ? e0 : e1);
    end
    u_i2c_host_model.stop();
  endtask : reg_read

  task automatic pulse_event;
    event_pulse_i = 1'b1;
    @(negedge clk_i);
    event_pulse_i = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : pulse_event

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    {resetn_i, charge_state_i, boost_active_i, batfet_present_i} = '0;
    {thermistor_present_i, otg_pin_i, battery_warm_i} = '0;
    {junction_hot_i, event_pulse_i} = '0;
    boost_phase_i = BOOST_WAIT;
    event_regs_i = '0;
    repeat (16) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (8) @(negedge clk_i);
    // reset values at the ports and through the bus
    check(8'(charge_enable_o), 8'h01);
    check(8'(temp_profile_enable_o), 8'h01);
    check(8'(interrupt_mask_o), 8'h01);
    check(8'(boost_request_o), 8'h00);
    reg_read(8'h01, 8'h51, 8'h00, 1);
    // every charge and boost code, presence bits and one pending flag
    for (int k = 0; k < 20; k++) begin
      boost_active_i = (k >= 16);
      charge_state_i = k[3:0];
      boost_phase_i = boost_phase_type'(k[1:0]);
      batfet_present_i = k[0];
      thermistor_present_i = k[1];
      event_regs_i = 32'h1 << ((k * 5) % 32);
      expv[7:4] = k < 12 ? k[3:0] : k < 16 ? 4'hB :
                  k[1:0] == 2'h3 ? 4'hE : 4'hC + {2'h0, k[1:0]};
      expv[3:0] = {k[0], k[1], |event_regs_i[31:24], |event_regs_i[23:0]};
      reg_read(8'h00, expv, 8'h00, 1);
    end
    // status write dropped, next byte lands at the following index
    battery_warm_i = 1'b1;
    junction_hot_i = 1'b1;
    set_index(8'h00);
    u_i2c_host_model.wr_byte(8'hAA, ack);
    u_i2c_host_model.wr_byte(8'h3C, ack);
    u_i2c_host_model.stop();
    repeat (2) @(negedge clk_i);
    check(8'(charge_enable_o), 8'h00);
    check(8'(boost_request_o), 8'h01);
    check(8'(current_derate_o), 8'h01);
    check(8'({charge_hold_o, charge_reduce_o}), 8'h01);
    check(8'(interrupt_mask_o), 8'h00);
    reg_read(8'h00, 8'hEE, 8'h3C, 2);
    reg_write(8'h01, 8'h10);
    check(8'(current_derate_o), 8'h00);
    check(8'({charge_hold_o, charge_reduce_o}), 8'h02);
    check(8'(boost_request_o), 8'h00);
    otg_pin_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check(8'(boost_request_o), 8'h01);
    otg_pin_i = 1'b0;
    reg_write(8'h01, 8'h00);
    check(8'(temp_profile_enable_o), 8'h00);
    check(8'({charge_hold_o, charge_reduce_o}), 8'h00);
    // event pulse passes unmasked, blocked when masked
    pulse_event();
    check(8'(n_flag), 8'h01);
    reg_write(8'h01, 8'h01);
    pulse_event();
    check(8'(n_flag), 8'h01);
    // self-clearing timer restart
    reg_write(8'h01, 8'h03);
    check(8'(n_restart), 8'h01);
    reg_read(8'h01, 8'h01, 8'h00, 1);
    // register reset leaves the status byte alone
    reg_write(8'h01, 8'h80);
    check(8'(n_regrst), 8'h01);
    reg_read(8'h01, 8'h51, 8'h00, 1);
    reg_read(8'h00, 8'hEE, 8'h00, 1);
    // foreign address gets no answer
    u_i2c_host_model.start();
    u_i2c_host_model.wr_byte(8'h6E, ack);
    u_i2c_host_model.stop();
    check(8'(ack), 8'h01);
    reg_read(8'h01, 8'h51, 8'h00, 1);
    tally_and_finish();
  end
endmodule : charger_status_control_regs_tb
